// File: rtl/rfm_params.svh
// timing constants and field widths for the resolver fault monitor
`ifndef RFM_PARAMS_SVH
`define RFM_PARAMS_SVH
`define RFM_CLK_HZ          20000000
`define RFM_INTEG_DEGL_NS   5000
`define RFM_SEOV_DEGL_NS    10000
`define RFM_ILIM_DEGL_NS    5000
`define RFM_EXC_MASK_US     10000
`define RFM_INTEG_DEGL_CYC  ((`RFM_INTEG_DEGL_NS * (`RFM_CLK_HZ / 1000000)) / 1000)
`define RFM_SEOV_DEGL_CYC   ((`RFM_SEOV_DEGL_NS * (`RFM_CLK_HZ / 1000000)) / 1000)
`define RFM_ILIM_DEGL_CYC   ((`RFM_ILIM_DEGL_NS * (`RFM_CLK_HZ / 1000000)) / 1000)
`define RFM_EXC_MASK_CYC    (`RFM_EXC_MASK_US * (`RFM_CLK_HZ / 1000000))
`define RFM_DUTY_HIGH_PCT   80
`define RFM_DUTY_LOW_PCT    20
`define RFM_UV_AND_DIV      32
`define RFM_DEGL_W          8
`define RFM_DEGL_UNIT       20
`define RFM_UV_OR           2'h0
`define RFM_UV_AND          2'h1
`define RFM_UV_ANDOR        2'h2
`endif

// File: rtl/rfm_pkg.sv
// types for the resolver fault monitor
package rfm_pkg;
   typedef enum logic [2:0] {
      RFM_ST_OFF  = 3'b001,
      RFM_ST_MASK = 3'b010,
      RFM_ST_RUN  = 3'b100
   } rfm_exc_st_t;
endpackage

// File: rtl/rfm_deglitch.sv
// deglitch timer: output rises once the condition has held for limit_i cycles
`timescale 1ns/1ps
module rfm_deglitch #(
   parameter int CW = 18
) (
   // clock and reset
   input  wire logic          clk_i,
   input  wire logic          sys_rst_i,
   // condition and period
   input  wire logic          cond_i,
   input  wire logic [CW-1:0] limit_i,
   // qualified result
   output logic               qual_o
);
   logic [CW-1:0] cnt_ff;
   logic [CW-1:0] nxt_cnt;
   logic          qual_ff;
   logic          nxt_qual;

   always_comb begin
      nxt_cnt  = cnt_ff;
      nxt_qual = 1'b0;
      if (!cond_i) begin
         nxt_cnt = '0;
      end else if (cnt_ff + 1'b1 >= limit_i) begin
         nxt_qual = 1'b1;
      end else begin
         nxt_cnt = cnt_ff + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cnt_ff  <= '0;
         qual_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         qual_ff <= nxt_qual;
      end
   end

   assign qual_o = qual_ff;
endmodule

// File: rtl/rfm_monitor.sv
// resolver input and exciter fault monitor: deglitch, flags, exciter shutdown
`timescale 1ns/1ps
`include "rfm_params.svh"
module rfm_monitor
   import rfm_pkg::*;
#(
   parameter int N_IN      = 4,
   parameter int CW        = 18,
   parameter int MASK_CYC  = `RFM_EXC_MASK_CYC,
   parameter int DUTY_CW   = 16
) (
   // clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  sys_rst_i,
   // comparator results from the analog side (asynchronous)
   input  wire logic [N_IN-1:0]       input_ov_high_cmp_i,
   input  wire logic [N_IN-1:0]       input_ov_low_cmp_i,
   input  wire logic [N_IN-1:0]       integrity_high_cmp_i,
   input  wire logic [N_IN-1:0]       integrity_low_cmp_i,
   input  wire logic                  sine_short_high_cmp_i,
   input  wire logic                  sine_short_low_cmp_i,
   input  wire logic                  cosine_short_high_cmp_i,
   input  wire logic                  cosine_short_low_cmp_i,
   input  wire logic                  sine_open_high_cmp_i,
   input  wire logic                  sine_open_low_cmp_i,
   input  wire logic                  cosine_open_high_cmp_i,
   input  wire logic                  cosine_open_low_cmp_i,
   input  wire logic                  loop_error_high_cmp_i,
   input  wire logic                  loop_error_low_cmp_i,
   input  wire logic                  ref_pulse_i,
   input  wire logic                  exciter_out_pos_ov_cmp_i,
   input  wire logic                  exciter_out_neg_ov_cmp_i,
   input  wire logic                  exciter_diff_ov_cmp_i,
   input  wire logic                  exciter_out_pos_uv_cmp_i,
   input  wire logic                  exciter_out_neg_uv_cmp_i,
   input  wire logic [1:0]            current_limit_high_cmp_i,
   input  wire logic [1:0]            current_limit_low_cmp_i,
   // configuration fields
   input  wire logic [`RFM_DEGL_W-1:0] input_short_deglitch_i,
   input  wire logic [`RFM_DEGL_W-1:0] mutual_short_deglitch_i,
   input  wire logic [`RFM_DEGL_W-1:0] open_deglitch_i,
   input  wire logic [`RFM_DEGL_W-1:0] loop_error_deglitch_i,
   input  wire logic [`RFM_DEGL_W-1:0] ref_duty_deglitch_i,
   input  wire logic [`RFM_DEGL_W-1:0] exciter_uv_deglitch_i,
   input  wire logic [`RFM_DEGL_W-1:0] exciter_ov_deglitch_i,
   input  wire logic [1:0]            uv_combine_select_i,
   input  wire logic                  exciter_mode_7v_i,
   input  wire logic [2:0]            current_limit_high_code_i,
   input  wire logic [2:0]            current_limit_low_code_i,
   // threshold selections passed to the analog comparators
   output logic                       exciter_mode_7v_o,
   output logic [2:0]                 current_limit_high_code_o,
   output logic [2:0]                 current_limit_low_code_o,
   // exciter control
   input  wire logic                  exciter_enable_i,
   input  wire logic                  flag_clear_i,
   output logic                       exciter_drive_en_o,
   // fault flags (sticky until flag_clear_i)
   output logic [N_IN-1:0]            input_high_short_flag_o,
   output logic [N_IN-1:0]            input_low_short_flag_o,
   output logic [N_IN-1:0]            integrity_high_flag_o,
   output logic [N_IN-1:0]            integrity_low_flag_o,
   output logic                       mutual_short_flag_o,
   output logic                       sine_open_high_flag_o,
   output logic                       sine_open_low_flag_o,
   output logic                       cosine_open_high_flag_o,
   output logic                       cosine_open_low_flag_o,
   output logic                       loop_stability_flag_o,
   output logic                       ref_duty_high_flag_o,
   output logic                       ref_duty_low_flag_o,
   output logic                       exciter_uv_flag_o,
   output logic                       exciter_ov_flag_o,
   output logic                       current_limit_flag_o,
   output logic                       exciter_se_ov_flag_o,
   output logic                       fault_o
);
   localparam int NC  = 4 * N_IN + 23;
   localparam int NF  = 4 * N_IN + 12;
   localparam int UNI = `RFM_DEGL_UNIT;

   // raw comparator vector, index map shared by sync and deglitch; the flags are repacked in set_vec
   logic [NC-1:0] raw;
   logic [NC-1:0] sync1_ff;
   logic [NC-1:0] sync2_ff;
   logic [NC-1:0] cond;
   logic [NC-1:0] qual;
   logic [CW-1:0] limit [NC];

   assign raw = {current_limit_low_cmp_i, current_limit_high_cmp_i,
                 exciter_out_neg_uv_cmp_i, exciter_out_pos_uv_cmp_i,
                 exciter_diff_ov_cmp_i, exciter_out_neg_ov_cmp_i,
                 exciter_out_pos_ov_cmp_i, ref_pulse_i,
                 loop_error_low_cmp_i, loop_error_high_cmp_i,
                 cosine_open_low_cmp_i, cosine_open_high_cmp_i,
                 sine_open_low_cmp_i, sine_open_high_cmp_i,
                 cosine_short_low_cmp_i, cosine_short_high_cmp_i,
                 sine_short_low_cmp_i, sine_short_high_cmp_i,
                 2'b00, 1'b0,
                 integrity_low_cmp_i, integrity_high_cmp_i,
                 input_ov_low_cmp_i, input_ov_high_cmp_i};

   localparam int I_SSH = 4 * N_IN + 3;
   localparam int I_OPN = I_SSH + 4;
   localparam int I_LPE = I_OPN + 4;
   localparam int I_REF = I_LPE + 2;
   localparam int I_SEO = I_REF + 1;
   localparam int I_DOV = I_SEO + 2;
   localparam int I_UVP = I_DOV + 1;
   localparam int I_ILM = I_UVP + 2;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end else begin
         sync1_ff <= raw;
         sync2_ff <= sync1_ff;
      end
   end

   // exciter enable mask sequencer
   rfm_exc_st_t   st_ff;
   rfm_exc_st_t   nxt_st;
   logic [31:0]   mcnt_ff;
   logic [31:0]   nxt_mcnt;
   logic          seov_trip;
   logic          exc_diag_on;

   always_comb begin
      nxt_st   = st_ff;
      nxt_mcnt = mcnt_ff;
      case (st_ff)
         RFM_ST_OFF: begin
            nxt_mcnt = '0;
            if (exciter_enable_i) begin
               nxt_st = RFM_ST_MASK;
            end
         end
         RFM_ST_MASK: begin
            nxt_mcnt = mcnt_ff + 32'h0000_0001;
            if (!exciter_enable_i) begin
               nxt_st = RFM_ST_OFF;
            end else if (mcnt_ff + 32'h0000_0001 >= 32'(MASK_CYC)) begin
               nxt_st = RFM_ST_RUN;
            end
         end
         RFM_ST_RUN: begin
            if (!exciter_enable_i) begin
               nxt_st = RFM_ST_OFF;
            end
         end
         default: begin
            nxt_st = RFM_ST_OFF;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         st_ff   <= RFM_ST_OFF;
         mcnt_ff <= '0;
      end else begin
         st_ff   <= nxt_st;
         mcnt_ff <= nxt_mcnt;
      end
   end

   assign exc_diag_on = (st_ff == RFM_ST_RUN);

   // duty measurement of the reference pulse over a fixed, repeating window
   logic [DUTY_CW-1:0] dwin_ff;
   logic [DUTY_CW-1:0] dhigh_ff;
   logic [DUTY_CW-1:0] nxt_dwin;
   logic [DUTY_CW-1:0] nxt_dhigh;
   logic               duty_hi_ff;
   logic               duty_lo_ff;
   logic               nxt_duty_hi;
   logic               nxt_duty_lo;

   // window of 2**DUTY_CW cycles covers several exciter periods
   always_comb begin
      nxt_dwin    = dwin_ff + 1'b1;
      nxt_dhigh   = dhigh_ff + DUTY_CW'(sync2_ff[I_REF]);
      nxt_duty_hi = duty_hi_ff;
      nxt_duty_lo = duty_lo_ff;
      if (&dwin_ff) begin
         nxt_duty_hi = ({7'h00, dhigh_ff} * 100) > ({7'h00, dwin_ff} * `RFM_DUTY_HIGH_PCT);
         nxt_duty_lo = ({7'h00, dhigh_ff} * 100) < ({7'h00, dwin_ff} * `RFM_DUTY_LOW_PCT);
         nxt_dhigh   = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         dwin_ff    <= '0;
         dhigh_ff   <= '0;
         duty_hi_ff <= 1'b0;
         duty_lo_ff <= 1'b0;
      end else begin
         dwin_ff    <= nxt_dwin;
         dhigh_ff   <= nxt_dhigh;
         duty_hi_ff <= nxt_duty_hi;
         duty_lo_ff <= nxt_duty_lo;
      end
   end

   // deglitch conditions and periods per channel
   logic [CW-1:0] uv_or_lim;
   logic [CW-1:0] uv_and_lim;
   logic          uv_either;
   logic          uv_both;
   logic          uv_fault;

   assign uv_or_lim  = CW'(exciter_uv_deglitch_i) * CW'(UNI);
   assign uv_and_lim = (uv_or_lim / CW'(`RFM_UV_AND_DIV)) + CW'(1);
   assign uv_either  = qual[I_UVP];
   assign uv_both    = qual[I_UVP + 1];

   always_comb begin
      cond = sync2_ff;
      for (int k = 0; k < NC; k++) begin
         limit[k] = CW'(1);
      end
      for (int k = 0; k < N_IN; k++) begin
         limit[k]          = CW'(input_short_deglitch_i) * CW'(UNI);
         limit[N_IN + k]   = CW'(input_short_deglitch_i) * CW'(UNI);
         limit[2*N_IN + k] = CW'(`RFM_INTEG_DEGL_CYC);
         limit[3*N_IN + k] = CW'(`RFM_INTEG_DEGL_CYC);
      end
      // spare slots hold the mutual short and duty conditions
      cond[4*N_IN]      = |sync2_ff[I_SSH +: 4];
      limit[4*N_IN]     = CW'(mutual_short_deglitch_i) * CW'(UNI);
      cond[4*N_IN + 1]  = duty_hi_ff & exc_diag_on;
      limit[4*N_IN + 1] = CW'(ref_duty_deglitch_i) * CW'(UNI);
      cond[4*N_IN + 2]  = duty_lo_ff & exc_diag_on;
      limit[4*N_IN + 2] = CW'(ref_duty_deglitch_i) * CW'(UNI);
      for (int k = 0; k < 4; k++) begin
         cond[I_SSH + k]  = 1'b0;
         limit[I_OPN + k] = CW'(open_deglitch_i) * CW'(UNI);
      end
      cond[I_LPE]      = |sync2_ff[I_LPE +: 2];
      cond[I_LPE + 1]  = 1'b0;
      limit[I_LPE]     = CW'(loop_error_deglitch_i) * CW'(UNI);
      cond[I_REF]      = 1'b0;
      cond[I_SEO]      = |sync2_ff[I_SEO +: 2] & exc_diag_on;
      cond[I_SEO + 1]  = 1'b0;
      limit[I_SEO]     = CW'(`RFM_SEOV_DEGL_CYC);
      cond[I_DOV]      = sync2_ff[I_DOV] & exc_diag_on;
      limit[I_DOV]     = CW'(exciter_ov_deglitch_i) * CW'(UNI);
      cond[I_UVP]      = |sync2_ff[I_UVP +: 2] & exc_diag_on;
      limit[I_UVP]     = uv_or_lim;
      cond[I_UVP + 1]  = &sync2_ff[I_UVP +: 2] & exc_diag_on;
      limit[I_UVP + 1] = uv_and_lim;
      cond[I_ILM]      = |sync2_ff[I_ILM +: 4] & exc_diag_on;
      limit[I_ILM]     = CW'(`RFM_ILIM_DEGL_CYC);
      for (int k = 1; k < 4; k++) begin
         cond[I_ILM + k] = 1'b0;
      end
   end

   for (genvar g = 0; g < NC; g++) begin : g_degl
      rfm_deglitch #(.CW(CW)) u_degl (
         .clk_i     (clk_i),
         .sys_rst_i (sys_rst_i),
         .cond_i    (cond[g]),
         .limit_i   (limit[g]),
         .qual_o    (qual[g])
      );
   end

   // combine the two undervoltage paths per the select field
   always_comb begin
      case (uv_combine_select_i)
         `RFM_UV_OR:    uv_fault = uv_either;
         `RFM_UV_AND:   uv_fault = uv_both;
         `RFM_UV_ANDOR: uv_fault = uv_either | uv_both;
         default:       uv_fault = uv_either;
      endcase
   end

   // sticky flags: a new event wins over a clear in the same cycle
   logic [NF-1:0] set_vec;
   logic [NF-1:0] flag_ff;
   logic [NF-1:0] nxt_flag;

   assign set_vec = {qual[I_SEO], qual[I_ILM], qual[I_DOV], uv_fault,
                     qual[4*N_IN + 2], qual[4*N_IN + 1], qual[I_LPE],
                     qual[I_OPN +: 4], qual[4*N_IN], qual[4*N_IN-1:0]};

   always_comb begin
      nxt_flag = flag_clear_i ? '0 : flag_ff;
      nxt_flag = nxt_flag | set_vec;
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         flag_ff <= '0;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   assign seov_trip = flag_ff[NF-1];

   assign input_high_short_flag_o = flag_ff[0 +: N_IN];
   assign input_low_short_flag_o  = flag_ff[N_IN +: N_IN];
   assign integrity_high_flag_o   = flag_ff[2*N_IN +: N_IN];
   assign integrity_low_flag_o    = flag_ff[3*N_IN +: N_IN];
   assign mutual_short_flag_o     = flag_ff[4*N_IN];
   assign sine_open_high_flag_o   = flag_ff[4*N_IN + 1];
   assign sine_open_low_flag_o    = flag_ff[4*N_IN + 2];
   assign cosine_open_high_flag_o = flag_ff[4*N_IN + 3];
   assign cosine_open_low_flag_o  = flag_ff[4*N_IN + 4];
   assign loop_stability_flag_o   = flag_ff[4*N_IN + 5];
   assign ref_duty_high_flag_o    = flag_ff[4*N_IN + 6];
   assign ref_duty_low_flag_o     = flag_ff[4*N_IN + 7];
   assign exciter_uv_flag_o       = flag_ff[4*N_IN + 8];
   assign exciter_ov_flag_o       = flag_ff[4*N_IN + 9];
   assign current_limit_flag_o    = flag_ff[4*N_IN + 10];
   assign exciter_se_ov_flag_o    = seov_trip;
   assign fault_o                 = |flag_ff;

   // single-ended over-voltage trip keeps the exciter off until the flag is cleared
   assign exciter_drive_en_o = exciter_enable_i & ~seov_trip;

   // threshold selections go straight to the comparators
   assign exciter_mode_7v_o         = exciter_mode_7v_i;
   assign current_limit_high_code_o = current_limit_high_code_i;
   assign current_limit_low_code_o  = current_limit_low_code_i;
endmodule

// File: tb/rfm_monitor_sva.sv
// port checker for the resolver fault monitor
`timescale 1ns/1ps
module rfm_monitor_sva
   import rfm_pkg::*;
#(
   parameter int N_IN     = 4,
   parameter int MASK_CYC = 200
) (
   // clock and reset
   input wire logic            clk_i,
   input wire logic            sys_rst_i,
   // watched inputs
   input wire logic [N_IN-1:0] integrity_high_cmp_i,
   input wire logic            exciter_out_pos_ov_cmp_i,
   input wire logic            exciter_out_neg_ov_cmp_i,
   input wire logic            exciter_out_neg_uv_cmp_i,
   input wire logic [1:0]      uv_combine_select_i,
   input wire logic            exciter_enable_i,
   input wire logic            flag_clear_i,
   // watched outputs
   input wire logic [N_IN-1:0] integrity_high_flag_o,
   input wire logic            exciter_uv_flag_o,
   input wire logic            exciter_se_ov_flag_o,
   input wire logic            exciter_drive_en_o,
   input wire logic            loop_stability_flag_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // run lengths saturate so that long holds stay valid
   logic [7:0] integ_run_ff;
   logic [7:0] se_run_ff;
   int         en_run_ff;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         integ_run_ff <= 8'h00;
         se_run_ff    <= 8'h00;
         en_run_ff    <= 0;
      end else begin
         integ_run_ff <= !integrity_high_cmp_i[0] ? 8'h00 :
                         integ_run_ff + 8'(integ_run_ff != 8'hff);
         se_run_ff    <= !(exciter_out_pos_ov_cmp_i || exciter_out_neg_ov_cmp_i) ? 8'h00 :
                         se_run_ff + 8'(se_run_ff != 8'hff);
         en_run_ff    <= !exciter_enable_i ? 0 : en_run_ff + int'(en_run_ff < 100000);
      end
   end
   sequence s_exc_live;
      en_run_ff >= MASK_CYC;
   endsequence
   sequence s_se_held;
      se_run_ff >= 8'hd2 && en_run_ff >= MASK_CYC + 240;
   endsequence
   AST_INTEG_QUAL: assert property ($rose(integrity_high_flag_o[0]) |->
      $past(integ_run_ff, 2) >= 8'h5f) else $error("integrity flag set before deglitch");
   AST_INTEG_SET: assert property (integ_run_ff >= 8'h6e |-> integrity_high_flag_o[0])
      else $error("integrity flag missing after deglitch");
   AST_SE_SET: assert property (s_se_held |-> exciter_se_ov_flag_o)
      else $error("output overvoltage not latched");
   AST_SE_QUAL: assert property ($rose(exciter_se_ov_flag_o) |->
      $past(se_run_ff, 2) >= 8'hbe) else $error("output overvoltage latched too early");
   AST_SE_OFF: assert property (exciter_se_ov_flag_o |-> !exciter_drive_en_o)
      else $error("exciter still driven after overvoltage");
   AST_EXC_MASK: assert property ($rose(exciter_se_ov_flag_o || exciter_uv_flag_o) |->
      s_exc_live) else $error("exciter flag set inside mask time");
   AST_UV_AND: assert property ($rose(exciter_uv_flag_o) && uv_combine_select_i == 2'h1 |->
      $past(exciter_out_neg_uv_cmp_i, 3)) else $error("both-output undervoltage without neg side");
   AST_LOOP_HOLD: assert property ($fell(loop_stability_flag_o) |-> $past(flag_clear_i))
      else $error("loop flag dropped without clear");
endmodule

bind rfm_monitor rfm_monitor_sva #(.N_IN(N_IN), .MASK_CYC(MASK_CYC)) u_sva (
   .clk_i, .sys_rst_i, .integrity_high_cmp_i, .exciter_out_pos_ov_cmp_i,
   .exciter_out_neg_ov_cmp_i, .exciter_out_neg_uv_cmp_i, .uv_combine_select_i,
   .exciter_enable_i, .flag_clear_i, .integrity_high_flag_o, .exciter_uv_flag_o,
   .exciter_se_ov_flag_o, .exciter_drive_en_o, .loop_stability_flag_o);

// File: tb/rfm_host_model.sv
// host model: clears flags on request while the fault pin calls, picks the combine code
`timescale 1ns/1ps
module rfm_host_model
   import rfm_pkg::*;
(
   // clock
   input  wire logic       clk_i,
   // bench requests
   input  wire logic       clear_req_i,
   input  wire logic [1:0] sel_req_i,
   input  wire logic       low_freq_i,
   // device side
   input  wire logic       fault_i,
   output logic            flag_clear_o,
   output logic [1:0]      uv_combine_select_o
);
   // outputs settle at the first edge, while the device is still in reset
   always @(posedge clk_i) begin
      // no clear without a fault to read, so a stray request is harmless
      flag_clear_o <= clear_req_i & fault_i;
      uv_combine_select_o <= low_freq_i ? 2'h0 : sel_req_i;
   end
endmodule

// File: tb/rfm_monitor_test.sv
// self-checking bench for the resolver fault monitor
`timescale 1ns/1ps
module rfm_monitor_test
   import rfm_pkg::*;
;
   localparam int MASK_CYC = 200;
   logic        clk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic [34:0] stim = '0;
   logic [7:0]  degl = 8'h02;
   logic        mode_7v = 1'b0;
   logic [2:0]  code_h = 3'h0;
   logic [2:0]  code_l = 3'h0;
   logic        exc_en = 1'b0;
   logic        clear_req = 1'b0;
   logic [1:0]  sel_req = 2'h0;
   logic        low_freq = 1'b0;
   logic [1:0]  ref_mode = 2'h2;
   logic        ref_pulse = 1'b0;
   wire         flag_clear, fault, drive_en, mode_7v_o;
   wire  [1:0]  uv_sel;
   wire  [2:0]  code_h_o, code_l_o;
   wire  [3:0]  ih, il, gh, gl;
   wire  [11:0] misc;
   wire  [29:0] obs = {fault, drive_en, misc, gl, gh, il, ih};
   int          n_errors = 0;
   int          n_tests = 0;

   always #25 clk_i = ~clk_i;
   always @(posedge clk_i) ref_pulse <= (ref_mode == 2'h2) ? ~ref_pulse : ref_mode[0];

   rfm_host_model u_host (.clk_i, .clear_req_i(clear_req), .sel_req_i(sel_req),
      .low_freq_i(low_freq), .fault_i(fault), .flag_clear_o(flag_clear),
      .uv_combine_select_o(uv_sel));

   rfm_monitor #(.MASK_CYC(MASK_CYC), .DUTY_CW(8)) u_dut (.clk_i, .sys_rst_i,
      .input_ov_high_cmp_i(stim[3:0]), .input_ov_low_cmp_i(stim[7:4]),
      .integrity_high_cmp_i(stim[11:8]), .integrity_low_cmp_i(stim[15:12]),
      .sine_short_high_cmp_i(stim[16]), .sine_short_low_cmp_i(stim[17]),
      .cosine_short_high_cmp_i(stim[18]), .cosine_short_low_cmp_i(stim[19]),
      .sine_open_high_cmp_i(stim[20]), .sine_open_low_cmp_i(stim[21]),
      .cosine_open_high_cmp_i(stim[22]), .cosine_open_low_cmp_i(stim[23]),
      .loop_error_high_cmp_i(stim[24]), .loop_error_low_cmp_i(stim[25]),
      .ref_pulse_i(ref_pulse), .exciter_out_pos_ov_cmp_i(stim[26]),
      .exciter_out_neg_ov_cmp_i(stim[27]), .exciter_diff_ov_cmp_i(stim[28]),
      .exciter_out_pos_uv_cmp_i(stim[29]), .exciter_out_neg_uv_cmp_i(stim[30]),
      .current_limit_high_cmp_i(stim[32:31]), .current_limit_low_cmp_i(stim[34:33]),
      .input_short_deglitch_i(degl), .mutual_short_deglitch_i(degl),
      .open_deglitch_i(degl), .loop_error_deglitch_i(degl), .ref_duty_deglitch_i(degl),
      .exciter_uv_deglitch_i(degl), .exciter_ov_deglitch_i(degl),
      .uv_combine_select_i(uv_sel), .exciter_mode_7v_i(mode_7v),
      .current_limit_high_code_i(code_h), .current_limit_low_code_i(code_l),
      .exciter_mode_7v_o(mode_7v_o), .current_limit_high_code_o(code_h_o),
      .current_limit_low_code_o(code_l_o), .exciter_enable_i(exc_en),
      .flag_clear_i(flag_clear), .exciter_drive_en_o(drive_en),
      .input_high_short_flag_o(ih), .input_low_short_flag_o(il),
      .integrity_high_flag_o(gh), .integrity_low_flag_o(gl),
      .mutual_short_flag_o(misc[0]), .sine_open_high_flag_o(misc[1]),
      .sine_open_low_flag_o(misc[2]), .cosine_open_high_flag_o(misc[3]),
      .cosine_open_low_flag_o(misc[4]), .loop_stability_flag_o(misc[5]),
      .ref_duty_high_flag_o(misc[6]), .ref_duty_low_flag_o(misc[7]),
      .exciter_uv_flag_o(misc[8]), .exciter_ov_flag_o(misc[9]),
      .current_limit_flag_o(misc[10]), .exciter_se_ov_flag_o(misc[11]), .fault_o(fault));

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // compares at the falling edge so the rising edge's updates have landed
   task automatic check(input logic [29:0] exp, input bit pins = 1'b0);
      logic [29:0] got;
      @(negedge clk_i);
      got = pins ? {23'h0, mode_7v_o, code_h_o, code_l_o} : obs;
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
      @(posedge clk_i);
   endtask

   task automatic clr;
      clear_req <= 1'b1;
      wait_cyc(1);
      clear_req <= 1'b0;
      wait_cyc(3);
   endtask

   task automatic final_report;
      $display("checks %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // two short pulses split by one idle cycle, then a steady crossing
   task automatic run(input int si, input int fi, input int p);
      logic [29:0] e;
      e = {1'b0, exc_en, 28'h0};
      stim[si] <= 1'b1;
      wait_cyc(p - 10);
      stim[si] <= 1'b0;
      wait_cyc(1);
      stim[si] <= 1'b1;
      wait_cyc(p - 10);
      stim[si] <= 1'b0;
      wait_cyc(p + 5);
      check(e);
      stim[si] <= 1'b1;
      wait_cyc(p + 12);
      e[fi] = 1'b1;
      e[29] = 1'b1;
      e[28] = exc_en && fi != 27;
      check(e);
      stim[si] <= 1'b0;
      wait_cyc(4);
      clr();
      check({1'b0, exc_en, 28'h0});
   endtask

   task automatic t_pass;
      for (int k = 0; k < 16; k++) begin
         mode_7v <= k[3];
         code_h <= k[2:0];
         code_l <= ~k[2:0];
         wait_cyc(1);
         check({23'h0, k[3], k[2:0], ~k[2:0]}, 1'b1);
      end
   endtask

   task automatic t_mask;
      stim[31] <= 1'b1;
      wait_cyc(150);
      check(30'h0);
      exc_en <= 1'b1;
      wait_cyc(150);
      check(30'h1000_0000);
      wait_cyc(180);
      check(30'h3400_0000);
      stim[31] <= 1'b0;
      wait_cyc(4);
      clr();
   endtask

   // last pass asks for the both-output code at a low exciter frequency
   task automatic t_uv;
      for (int j = 0; j < 4; j++) begin
         sel_req <= (j == 3) ? 2'h1 : 2'(j);
         low_freq <= (j == 3);
         wait_cyc(2);
         stim[29] <= 1'b1;
         wait_cyc(50);
         check({j != 1, 1'b1, 3'h0, j != 1, 24'h0});
         stim[29] <= 1'b0;
         wait_cyc(4);
         clr();
         stim[30:29] <= 2'b11;
         wait_cyc(8);
         check({j == 1 || j == 2, 1'b1, 3'h0, j == 1 || j == 2, 24'h0});
         stim[30:29] <= 2'b00;
         wait_cyc(4);
         clr();
      end
   endtask

   task automatic t_duty;
      for (int j = 1; j >= 0; j--) begin
         ref_mode <= 2'(j);
         wait_cyc(800);
         check({2'b11, 4'h0, j == 0, j == 1, 22'h0});
         ref_mode <= 2'h2;
         wait_cyc(600);
         clr();
         check(30'h1000_0000);
      end
   endtask

   initial begin
      wait_cyc(3);
      sys_rst_i <= 1'b0;
      check(30'h0);
      t_pass();
      for (int k = 0; k < 4; k++) begin
         run(k, k, 40);
         run(4 + k, 4 + k, 40);
         run(8 + k, 8 + k, 100);
         run(12 + k, 12 + k, 100);
         run(16 + k, 16, 40);
         run(20 + k, 17 + k, 40);
      end
      run(24, 21, 40);
      run(25, 21, 40);
      t_mask();
      run(28, 25, 40);
      run(29, 24, 40);
      run(30, 24, 40);
      for (int k = 31; k < 35; k++) begin
         run(k, 26, 100);
      end
      run(26, 27, 200);
      run(27, 27, 200);
      t_uv();
      t_duty();
      final_report();
   end
endmodule
